// >>> fcr_regs.sv
// Module: flash status and boot configuration registers
//
// Behaviour
// - Boot loads working configuration from boot word.
// - Volatile writes reach working configuration at once.
// - Boot discards volatile settings.
// - Status bit 7 with the pin disables status writes.
// - Status bit 5 sets protected range origin, 0 top.
// - Nonzero protect bits 6,4:2 refuse protected program/erase.
// - Write latch clear at reset; needed for any write except volatile writes.
// - Status bit 0 is 1 while a write cycle runs.
// - Bit 7 set and pin low lock status writes.
// - Bulk erase needs all protect bits 0.
// - Reset clears volatile status bits.
// - Status read and written by own commands.
// - Boot bits 15:12 set dummy cycles; 0 and F mean default.
// - Boot bits 11:9 pick execute-in-place mode; 7 is off.
// - Boot bits 8:6 pick output drive; 7 is default.
// - Boot bit 4 enables the hold or reset function.
// - Boot bits 3, 2 low pick four- or two-line protocol.
// - Boot word ships all ones; own access commands.
// - Both protocol bits low pick four lines.
// - Inputs taken on rising edge; outputs registered on rising edge.
`timescale 1ns/100ps
`default_nettype none
module fcr_regs
    import fcr_pkg::*;
#(
    parameter int WR_CYCLES = FCR_WR_CYCLES,
    parameter int PE_CYCLES = FCR_PE_CYCLES
)(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Power-on boot strobe
    input  wire logic              boot,
    // Command port
    input  wire logic              cmd_valid,
    input  wire fcr_pkg::fcr_cmd_t cmd,
    input  wire logic [15:0]       cmd_data,
    input  wire logic              target_protected,
    // Write protect pin, active low
    input  wire logic              write_protect_n,
    // Read answer
    output logic [15:0]            rd_data,
    output logic                   rd_valid,
    output logic                   cmd_rejected,
    // Working configuration
    output logic [7:0]             flash_status,
    output logic [15:0]            boot_configuration,
    output logic [3:0]             dummy_cycles,
    output logic [2:0]             execute_in_place,
    output logic [2:0]             drive_code,
    output logic                   hold_enable,
    output logic [1:0]             protocol,
    output logic                   block_protect_active,
    output logic                   protect_range_origin
);
    initial begin
        if (WR_CYCLES < 1 || WR_CYCLES > 65535 ||
            PE_CYCLES < 1 || PE_CYCLES > 65535)
            $error("bad busy counts");
    end

    typedef enum logic [1:0] {
        FCR_IDLE  = 2'b00,
        FCR_BUSY  = 2'b01,
        FCR_APPLY = 2'b11
    } fcr_state_t;

    typedef enum logic [1:0] {
        FCR_OP_SR = 2'h0,
        FCR_OP_NV = 2'h1,
        FCR_OP_PE = 2'h2
    } fcr_op_t;

    fcr_state_t  state_q,  next_state;
    fcr_op_t     op_q,     next_op;
    logic [15:0] cnt_q,    next_cnt;
    logic [7:0]  sr_q,     next_sr;
    logic [15:0] nv_q,     next_nv;
    logic [15:0] pend_q,   next_pend;
    logic [7:0]  vcr_q,    next_vcr;
    logic [7:0]  evcr_q,   next_evcr;
    logic [15:0] rd_q,     next_rd;
    logic        rdv_q,    next_rdv;
    logic        rej_q,    next_rej;
    logic        live_q,   next_live;
    logic        boot_q,   next_boot;

    fcr_cfg_if cfg_bus ();

    function automatic logic [3:0] bp_of(input logic [7:0] s);
        bp_of = {s[FCR_SR_BP3], s[FCR_SR_BP2:FCR_SR_BP0]};
    endfunction : bp_of

    logic sr_locked;
    logic [3:0] bp;
    assign sr_locked = sr_q[FCR_SR_SWD] & ~write_protect_n;
    assign bp        = bp_of(sr_q);

    always_comb begin
        next_state = state_q;
        next_op    = op_q;
        next_cnt   = cnt_q;
        next_sr    = sr_q;
        next_nv    = nv_q;
        next_pend  = pend_q;
        next_vcr   = vcr_q;
        next_evcr  = evcr_q;
        next_rd    = rd_q;
        next_rdv   = 1'b0;
        next_rej   = 1'b0;
        next_live  = 1'b0;
        next_boot  = boot;
        unique case (state_q)
            FCR_IDLE: begin
                if (cmd_valid) begin
                    unique case (cmd)
                        FCR_CMD_WREN:
                            next_sr[FCR_SR_WEL] = 1'b1;
                        FCR_CMD_WRDI:
                            next_sr[FCR_SR_WEL] = 1'b0;
                        FCR_CMD_RDSR: begin
                            next_rd  = {8'h00, sr_q};
                            next_rdv = 1'b1;
                        end
                        FCR_CMD_RDNVCR: begin
                            next_rd  = nv_q;
                            next_rdv = 1'b1;
                        end
                        FCR_CMD_WRSR: begin
                            if (!sr_q[FCR_SR_WEL] || sr_locked) begin
                                next_rej = 1'b1;
                            end else begin
                                next_pend  = {8'h00, cmd_data[7:0]};
                                next_op    = FCR_OP_SR;
                                next_cnt   = 16'(WR_CYCLES);
                                next_state = FCR_BUSY;
                            end
                        end
                        FCR_CMD_WRNVCR: begin
                            if (!sr_q[FCR_SR_WEL]) begin
                                next_rej = 1'b1;
                            end else begin
                                next_pend  = cmd_data;
                                next_op    = FCR_OP_NV;
                                next_cnt   = 16'(WR_CYCLES);
                                next_state = FCR_BUSY;
                            end
                        end
                        FCR_CMD_WRVCR: begin
                            next_vcr  = cmd_data[7:0];
                            next_live = 1'b1;
                        end
                        FCR_CMD_WREVCR: begin
                            next_evcr = cmd_data[7:0];
                            next_live = 1'b1;
                        end
                        FCR_CMD_PROGRAM, FCR_CMD_ERASE,
                        FCR_CMD_BULKERASE: begin
                            if (!sr_q[FCR_SR_WEL]
                                || (cmd == FCR_CMD_BULKERASE
                                    && bp != 4'h0)
                                || (cmd != FCR_CMD_BULKERASE
                                    && bp != 4'h0
                                    && target_protected)) begin
                                next_rej            = 1'b1;
                                next_sr[FCR_SR_WEL] = 1'b0;
                            end else begin
                                next_op    = FCR_OP_PE;
                                next_cnt   = 16'(PE_CYCLES);
                                next_state = FCR_BUSY;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            FCR_BUSY: begin
                next_sr[FCR_SR_WIP] = 1'b1;
                if (cmd_valid && cmd == FCR_CMD_RDSR) begin
                    next_rd  = {8'h00, sr_q};
                    next_rdv = 1'b1;
                end else if (cmd_valid) begin
                    next_rej = 1'b1;
                end
                if (cnt_q <= 16'h0001)
                    next_state = FCR_APPLY;
                else
                    next_cnt = cnt_q - 16'h0001;
            end
            FCR_APPLY: begin
                if (op_q == FCR_OP_SR)
                    next_sr = (pend_q[7:0] & FCR_SR_NV_MASK)
                            | (sr_q & ~FCR_SR_NV_MASK);
                else if (op_q == FCR_OP_NV)
                    next_nv = pend_q;
                next_sr[FCR_SR_WIP] = 1'b0;
                next_sr[FCR_SR_WEL] = 1'b0;
                next_state = FCR_IDLE;
            end
            default: next_state = FCR_IDLE;
        endcase
        if (boot) begin
            next_vcr  = 8'hFB;
            next_evcr = 8'hFF;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= FCR_IDLE;
            op_q    <= FCR_OP_SR;
            cnt_q   <= 16'h0000;
            sr_q    <= FCR_SR_RESET;
            nv_q    <= FCR_NV_RESET;
            pend_q  <= 16'h0000;
            vcr_q   <= 8'hFB;
            evcr_q  <= 8'hFF;
            rd_q    <= 16'h0000;
            rdv_q   <= 1'b0;
            rej_q   <= 1'b0;
            live_q  <= 1'b0;
            boot_q  <= 1'b0;
        end else begin
            state_q <= next_state;
            op_q    <= next_op;
            cnt_q   <= next_cnt;
            sr_q    <= next_sr;
            nv_q    <= next_nv;
            pend_q  <= next_pend;
            vcr_q   <= next_vcr;
            evcr_q  <= next_evcr;
            rd_q    <= next_rd;
            rdv_q   <= next_rdv;
            rej_q   <= next_rej;
            live_q  <= next_live;
            boot_q  <= next_boot;
        end
    end

    // Boot load reads the stored word
    assign cfg_bus.load_boot = boot_q;
    assign cfg_bus.load_live = live_q;
    assign cfg_bus.boot_word = nv_q;
    assign cfg_bus.vol_word  = vcr_q;
    assign cfg_bus.evol_word = evcr_q;

    fcr_working_cfg u_cfg (
        .clk (clk),
        .rst (rst),
        .cfg (cfg_bus)
    );

    // Output registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dummy_cycles         <= FCR_DUMMY_DEFAULT;
            execute_in_place     <= FCR_XIP_OFF;
            drive_code           <= FCR_DRV_DEFAULT;
            hold_enable          <= 1'b1;
            protocol             <= FCR_PROTO_EXT;
            block_protect_active <= 1'b0;
            protect_range_origin <= 1'b0;
            flash_status         <= FCR_SR_RESET;
            boot_configuration   <= FCR_NV_RESET;
            rd_data              <= 16'h0000;
            rd_valid             <= 1'b0;
            cmd_rejected         <= 1'b0;
        end else begin
            dummy_cycles         <= cfg_bus.dummy_cycles;
            execute_in_place     <= cfg_bus.execute_in_place;
            drive_code           <= cfg_bus.drive_code;
            hold_enable          <= cfg_bus.hold_enable;
            protocol             <= cfg_bus.protocol;
            block_protect_active <= |bp;
            protect_range_origin <= sr_q[FCR_SR_ORG];
            flash_status         <= sr_q;
            boot_configuration   <= nv_q;
            rd_data              <= rd_q;
            rd_valid             <= rdv_q;
            cmd_rejected         <= rej_q;
        end
    end
endmodule : fcr_regs
`default_nettype wire

// >>> fcr_pkg.sv
// Package: constants for the flash configuration and status register bank
package fcr_pkg;
    // Command codes
    typedef enum logic [3:0] {
        FCR_CMD_NONE      = 4'h0,
        FCR_CMD_WREN      = 4'h1,
        FCR_CMD_WRDI      = 4'h2,
        FCR_CMD_RDSR      = 4'h3,
        FCR_CMD_WRSR      = 4'h4,
        FCR_CMD_RDNVCR    = 4'h5,
        FCR_CMD_WRNVCR    = 4'h6,
        FCR_CMD_WRVCR     = 4'h7,
        FCR_CMD_WREVCR    = 4'h8,
        FCR_CMD_PROGRAM   = 4'h9,
        FCR_CMD_ERASE     = 4'hA,
        FCR_CMD_BULKERASE = 4'hB
    } fcr_cmd_t;

    // Status bit positions
    localparam int FCR_SR_WIP   = 0;
    localparam int FCR_SR_WEL   = 1;
    localparam int FCR_SR_BP0   = 2;
    localparam int FCR_SR_BP2   = 4;
    localparam int FCR_SR_ORG   = 5;
    localparam int FCR_SR_BP3   = 6;
    localparam int FCR_SR_SWD   = 7;
    localparam logic [7:0] FCR_SR_NV_MASK = 8'hFC;

    // Boot configuration field positions
    localparam int FCR_NV_DUMMY_LO = 12;
    localparam int FCR_NV_XIP_LO   = 9;
    localparam int FCR_NV_DRV_LO   = 6;
    localparam int FCR_NV_HOLD     = 4;
    localparam int FCR_NV_QUAD     = 3;
    localparam int FCR_NV_DUAL     = 2;

    // Reset values
    localparam logic [15:0] FCR_NV_RESET = 16'hFFFF;
    localparam logic [7:0]  FCR_SR_RESET = 8'h00;
    localparam logic [3:0]  FCR_DUMMY_DEFAULT = 4'hF;
    localparam logic [2:0]  FCR_XIP_OFF       = 3'h7;
    localparam logic [2:0]  FCR_DRV_DEFAULT   = 3'h7;

    // Protocol codes
    localparam logic [1:0] FCR_PROTO_EXT  = 2'h0;
    localparam logic [1:0] FCR_PROTO_DUAL = 2'h1;
    localparam logic [1:0] FCR_PROTO_QUAD = 2'h2;

    // Busy times in clock cycles
    localparam int FCR_WR_CYCLES = 16;
    localparam int FCR_PE_CYCLES = 64;
endpackage : fcr_pkg

// >>> fcr_cfg_if.sv
// Interface: working configuration passed from loader to top
`timescale 1ns/100ps
`default_nettype none
interface fcr_cfg_if;
    logic       load_boot;
    logic       load_live;
    logic [15:0] boot_word;
    logic [7:0]  vol_word;
    logic [7:0]  evol_word;
    logic [3:0]  dummy_cycles;
    logic [2:0]  execute_in_place;
    logic [2:0]  drive_code;
    logic        hold_enable;
    logic [1:0]  protocol;
    modport master (output load_boot, load_live, boot_word, vol_word,
                    evol_word, input dummy_cycles, execute_in_place,
                    drive_code, hold_enable, protocol);
    modport slave (input load_boot, load_live, boot_word, vol_word,
                   evol_word, output dummy_cycles, execute_in_place,
                   drive_code, hold_enable, protocol);
endinterface : fcr_cfg_if
`default_nettype wire

// >>> fcr_working_cfg.sv
// Module: hidden working configuration loaded at boot or by volatile writes
`timescale 1ns/100ps
`default_nettype none
module fcr_working_cfg
    import fcr_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Load requests and working values
    fcr_cfg_if.slave  cfg
);
    logic [3:0] dummy_q,  next_dummy;
    logic [2:0] xip_q,    next_xip;
    logic [2:0] drv_q,    next_drv;
    logic       hold_q,   next_hold;
    logic [1:0] proto_q,  next_proto;

    function automatic logic [1:0] proto_of(input logic quad_n,
                                            input logic dual_n);
        if (!quad_n)
            proto_of = FCR_PROTO_QUAD;
        else if (!dual_n)
            proto_of = FCR_PROTO_DUAL;
        else
            proto_of = FCR_PROTO_EXT;
    endfunction : proto_of

    function automatic logic [3:0] dummy_of(input logic [3:0] code);
        dummy_of = (code == 4'h0) ? FCR_DUMMY_DEFAULT : code;
    endfunction : dummy_of

    always_comb begin
        next_dummy = dummy_q;
        next_xip   = xip_q;
        next_drv   = drv_q;
        next_hold  = hold_q;
        next_proto = proto_q;
        if (cfg.load_boot) begin
            next_dummy = dummy_of(cfg.boot_word[FCR_NV_DUMMY_LO +: 4]);
            next_xip   = cfg.boot_word[FCR_NV_XIP_LO +: 3];
            next_drv   = cfg.boot_word[FCR_NV_DRV_LO +: 3];
            next_hold  = cfg.boot_word[FCR_NV_HOLD];
            next_proto = proto_of(cfg.boot_word[FCR_NV_QUAD],
                                  cfg.boot_word[FCR_NV_DUAL]);
        end else if (cfg.load_live) begin
            next_dummy = dummy_of(cfg.vol_word[7:4]);
            next_xip   = cfg.vol_word[3] ? FCR_XIP_OFF : 3'h0;
            next_hold  = cfg.evol_word[4];
            next_proto = proto_of(cfg.evol_word[7], cfg.evol_word[6]);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dummy_q <= FCR_DUMMY_DEFAULT;
            xip_q   <= FCR_XIP_OFF;
            drv_q   <= FCR_DRV_DEFAULT;
            hold_q  <= 1'b1;
            proto_q <= FCR_PROTO_EXT;
        end else begin
            dummy_q <= next_dummy;
            xip_q   <= next_xip;
            drv_q   <= next_drv;
            hold_q  <= next_hold;
            proto_q <= next_proto;
        end
    end

    assign cfg.dummy_cycles     = dummy_q;
    assign cfg.execute_in_place = xip_q;
    assign cfg.drive_code       = drv_q;
    assign cfg.hold_enable      = hold_q;
    assign cfg.protocol         = proto_q;
endmodule : fcr_working_cfg
`default_nettype wire

// >>> fcr_regs_props.sv
// Checker: port properties of the register bank
`timescale 1ns/100ps
`default_nettype none
module fcr_regs_props
    import fcr_pkg::*;
#(
    parameter int WR_CYCLES = FCR_WR_CYCLES,
    parameter int PE_CYCLES = FCR_PE_CYCLES
)(
    // Clock and reset
    input wire logic              clk,
    input wire logic              rst,
    // Command side
    input wire logic              cmd_valid,
    input wire fcr_pkg::fcr_cmd_t cmd,
    input wire logic              target_protected,
    input wire logic              write_protect_n,
    // Answers and state
    input wire logic [15:0]       rd_data,
    input wire logic              rd_valid,
    input wire logic              cmd_rejected,
    input wire logic [7:0]        flash_status,
    input wire logic [15:0]       boot_configuration,
    input wire logic              block_protect_active
);
    logic [2:0] recent;
    logic [2:0] next_recent;
    logic       quiet;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Commands of the last three cycles
    always_comb begin
        next_recent = {recent[1:0], cmd_valid};
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            recent <= 3'h0;
        end else begin
            recent <= next_recent;
        end
    end
    assign quiet = (recent == 3'h0);

    ans_cause_a: assert property (
        (rd_valid || cmd_rejected) |-> $past(cmd_valid, 2))
        else $error("stray answer");
    rdsr_ans_a: assert property (
        cmd_valid && cmd == FCR_CMD_RDSR |-> ##2 rd_valid)
        else $error("no read answer");
    nv_read_a: assert property (
        cmd_valid && cmd == FCR_CMD_RDNVCR && quiet && !flash_status[0]
        |-> ##2 rd_valid && rd_data == $past(boot_configuration, 2))
        else $error("boot read wrong");
    wel_need_a: assert property (
        cmd_valid && (cmd == FCR_CMD_WRSR || cmd == FCR_CMD_WRNVCR)
        && quiet && !flash_status[1] |-> ##2 cmd_rejected)
        else $error("no latch");
    swd_lock_a: assert property (
        cmd_valid && cmd == FCR_CMD_WRSR && quiet && flash_status[7]
        && !write_protect_n |-> ##2 cmd_rejected)
        else $error("lock ignored");
    bulk_bp_a: assert property (
        cmd_valid && cmd == FCR_CMD_BULKERASE && quiet
        && block_protect_active |-> ##2 cmd_rejected)
        else $error("bulk erase ran");
    bp_range_a: assert property (
        cmd_valid && (cmd == FCR_CMD_PROGRAM || cmd == FCR_CMD_ERASE)
        && quiet && block_protect_active && target_protected
        |-> ##2 cmd_rejected)
        else $error("protected write ran");
    busy_end_a: assert property (
        $fell(flash_status[0]) |-> !flash_status[1])
        else $error("latch left set");
    busy_len_a: assert property (
        $rose(flash_status[0])
        |-> flash_status[0][*2] ##[1:300] !flash_status[0])
        else $error("busy length");
    reset_val_a: assert property (
        $fell(rst) |-> flash_status == FCR_SR_RESET)
        else $error("reset status");
endmodule : fcr_regs_props

bind fcr_regs fcr_regs_props #(
    .WR_CYCLES(WR_CYCLES),
    .PE_CYCLES(PE_CYCLES)
) fcr_regs_props_i (
    .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .target_protected(target_protected),
    .write_protect_n(write_protect_n), .rd_data(rd_data),
    .rd_valid(rd_valid), .cmd_rejected(cmd_rejected),
    .flash_status(flash_status),
    .boot_configuration(boot_configuration),
    .block_protect_active(block_protect_active)
);
`default_nettype wire

// >>> fcr_master_model.sv
// Partner: bus master issuing register commands
`timescale 1ns/100ps
`default_nettype none
module fcr_master_model
    import fcr_pkg::*;
(
    // Clock and status seen by the master
    input  wire logic              clk,
    input  wire logic [7:0]        flash_status,
    // Command port
    output var logic               cmd_valid,
    output var fcr_pkg::fcr_cmd_t  cmd,
    output var logic [15:0]        cmd_data
);
    initial begin
        cmd_valid = 1'b0;
        cmd = FCR_CMD_NONE;
        cmd_data = 16'h0000;
    end

    // One command, held for one edge
    task automatic issue(input fcr_cmd_t c, input logic [15:0] d,
                         input int gap);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        #10;
        cmd_valid = 1'b1;
        cmd = c;
        cmd_data = d;
        @(posedge clk);
        #10;
        cmd_valid = 1'b0;
        cmd = FCR_CMD_NONE;
        cmd_data = ~d;
    endtask : issue

    // Poll busy until ready
    task automatic wait_ready(output logic ok);
        int n;
        n = 0;
        while (flash_status[FCR_SR_WIP] !== 1'b0 && n < 400) begin
            @(posedge clk);
            #10;
            n++;
        end
        ok = (n < 400);
        repeat (2) @(posedge clk);
        #10;
    endtask : wait_ready
endmodule : fcr_master_model
`default_nettype wire

// >>> tb_top.sv
// Testbench: self-checking run of the register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import fcr_pkg::*;
    typedef struct packed {
        logic        rej;
        logic [15:0] dat;
        logic [15:0] msk;
    } fcr_note_t;
    logic        clk;
    logic        rst;
    logic        boot;
    logic        cmd_valid;
    fcr_cmd_t    cmd;
    logic [15:0] cmd_data;
    logic        target_protected;
    logic        write_protect_n;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        cmd_rejected;
    logic [7:0]  flash_status;
    logic [15:0] boot_configuration;
    logic [3:0]  dummy_cycles;
    logic [2:0]  execute_in_place;
    logic [2:0]  drive_code;
    logic        hold_enable;
    logic [1:0]  protocol;
    logic        block_protect_active;
    logic        protect_range_origin;
    fcr_note_t   notes[$];
    fcr_note_t   nt;
    int          err_count;
    int          checked;
    logic        ok;
    logic [15:0] w;
    logic [15:0] prev;
    logic [15:0] words[4];

    fcr_regs #(.WR_CYCLES(2), .PE_CYCLES(2)) fcr_regs_i (
        .clk(clk), .rst(rst), .boot(boot), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_data(cmd_data),
        .target_protected(target_protected),
        .write_protect_n(write_protect_n), .rd_data(rd_data),
        .rd_valid(rd_valid), .cmd_rejected(cmd_rejected),
        .flash_status(flash_status),
        .boot_configuration(boot_configuration),
        .dummy_cycles(dummy_cycles), .execute_in_place(execute_in_place),
        .drive_code(drive_code), .hold_enable(hold_enable),
        .protocol(protocol), .block_protect_active(block_protect_active),
        .protect_range_origin(protect_range_origin)
    );
    fcr_master_model fcr_master_model_i (
        .clk(clk), .flash_status(flash_status), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_data(cmd_data)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    // Kind 0 no answer, 1 refused, 2 read answer e
    task automatic send(input fcr_cmd_t c, input logic [15:0] d,
                        input int kind, input logic [15:0] e);
        if (kind == 1)
            notes.push_back('{1'b1, 16'h0000, 16'h0000});
        if (kind == 2)
            notes.push_back('{1'b0, e,
                (c == FCR_CMD_RDSR) ? 16'h00FF : 16'hFFFF});
        fcr_master_model_i.issue(c, d, $urandom_range(2));
        repeat (3) @(posedge clk);
        #10;
    endtask : send

    task automatic wren();
        send(FCR_CMD_WREN, 16'h0000, 0, 16'h0000);
    endtask : wren

    task automatic wr(input fcr_cmd_t c, input logic [15:0] d);
        int n;
        wren();
        fcr_master_model_i.issue(c, d, 0);
        n = 0;
        while (flash_status[FCR_SR_WIP] !== 1'b1 && n < 10) begin
            @(posedge clk);
            #10;
            n++;
        end
        check("busy seen", 16'(n < 10), 16'h0001);
        fcr_master_model_i.wait_ready(ok);
        check("ready", 16'(ok), 16'h0001);
    endtask : wr

    task automatic check_cfg(input logic [15:0] b);
        logic [3:0] d;
        logic [1:0] p;
        d = (b[15:12] == 4'h0) ? FCR_DUMMY_DEFAULT : b[15:12];
        p = !b[3] ? FCR_PROTO_QUAD : (!b[2] ? FCR_PROTO_DUAL : FCR_PROTO_EXT);
        check("dummy", dummy_cycles, d);
        check("xip", execute_in_place, b[11:9]);
        check("drive", drive_code, b[8:6]);
        check("hold", hold_enable, b[4]);
        check("protocol", protocol, p);
    endtask : check_cfg

    task automatic do_boot();
        @(posedge clk);
        #10;
        boot = 1'b1;
        @(posedge clk);
        #10;
        boot = 1'b0;
        repeat (4) @(posedge clk);
        #10;
    endtask : do_boot

    // Answer checker
    always @(posedge clk) begin
        if (!rst && (rd_valid === 1'b1 || cmd_rejected === 1'b1)) begin
            if (notes.size() == 0) begin
                check("extra answer", 16'h0001, 16'h0000);
            end else begin
                nt = notes.pop_front();
                check("refused", 16'(cmd_rejected), 16'(nt.rej));
                check("rd_data", rd_data & nt.msk, nt.dat & nt.msk);
            end
        end
    end

    initial begin
        #2000000;
        err_count++;
        final_report();
    end

    initial begin
        rst = 1'b1;
        boot = 1'b0;
        target_protected = 1'b0;
        write_protect_n = 1'b1;
        err_count = 0;
        checked = 0;
        void'($urandom(45));
        repeat (5) @(posedge clk);
        #10;
        rst = 1'b0;
        @(posedge clk);
        #10;
        check("status", flash_status, FCR_SR_RESET);
        check("boot word", boot_configuration, FCR_NV_RESET);
        check_cfg(FCR_NV_RESET);
        send(FCR_CMD_RDSR, 16'h0000, 2, 16'h0000);
        send(FCR_CMD_RDNVCR, 16'h0000, 2, FCR_NV_RESET);
        send(FCR_CMD_WRSR, 16'h0024, 1, 16'h0000);
        send(FCR_CMD_WRNVCR, 16'h0000, 1, 16'h0000);
        wren();
        check("latch", flash_status[FCR_SR_WEL], 1'b1);
        wr(FCR_CMD_WRSR, 16'h0024);
        check("status", flash_status, 8'h24);
        check("origin", protect_range_origin, 1'b1);
        check("protect", block_protect_active, 1'b1);
        wren();
        send(FCR_CMD_BULKERASE, 16'h0000, 1, 16'h0000);
        check("latch", flash_status[FCR_SR_WEL], 1'b0);
        target_protected = 1'b1;
        wren();
        send(FCR_CMD_PROGRAM, 16'h0000, 1, 16'h0000);
        wren();
        send(FCR_CMD_ERASE, 16'h0000, 1, 16'h0000);
        target_protected = 1'b0;
        wr(FCR_CMD_PROGRAM, 16'h0000);
        wr(FCR_CMD_WRSR, 16'h0080);
        write_protect_n = 1'b0;
        wren();
        send(FCR_CMD_WRSR, 16'h0000, 1, 16'h0000);
        check("locked", flash_status & FCR_SR_NV_MASK, 8'h80);
        write_protect_n = 1'b1;
        wr(FCR_CMD_WRSR, 16'h0000);
        check("unlocked", flash_status, 8'h00);
        wr(FCR_CMD_BULKERASE, 16'h0000);
        send(FCR_CMD_RDSR, 16'h0000, 2, 16'h0000);
        w = 16'($urandom);
        words[0] = 16'h0000;
        words[1] = 16'hFFFB;
        words[2] = {w[15:12], 3'h3, 3'h1, w[5:0]};
        words[3] = {w[11:8], 3'h0, 3'h6, w[5:0]};
        prev = FCR_NV_RESET;
        foreach (words[i]) begin
            wr(FCR_CMD_WRNVCR, words[i]);
            send(FCR_CMD_RDNVCR, 16'h0000, 2, words[i]);
            check_cfg(prev);
            do_boot();
            check_cfg(words[i]);
            prev = words[i];
        end
        send(FCR_CMD_WRVCR, 16'h0050, 0, 16'h0000);
        check("vol dummy", dummy_cycles, 4'h5);
        check("vol xip", execute_in_place, 3'h0);
        send(FCR_CMD_WREVCR, 16'h007F, 0, 16'h0000);
        check("vol proto", protocol, FCR_PROTO_QUAD);
        do_boot();
        check_cfg(prev);
        wren();
        rst = 1'b1;
        @(posedge clk);
        #10;
        rst = 1'b0;
        @(posedge clk);
        #10;
        check("status", flash_status, 8'h00);
        check("notes left", 16'(notes.size()), 16'h0000);
        final_report();
    end
endmodule : tb_top
`default_nettype wire
